// [mcap_device.sv]
// codec end of the mono audio serial port: control words, clock generator, shifter
// Function
// [R1] four pins: capture out, playback in, sync, bit clock
// [R2] master bit high: device makes both clocks
// [R3] master bit low: follow clocks from the host
// [R4] every format shifts words msb first
// [R5] left justified: msb on first rise after transition
// [R6] right justified: lsb on last rise before transition
// [R7] i2s: msb on second rise after transition
// [R8] dsp: msb on rise 1 or 2, right follows
// [R9] master clocks divided down from master clock
// [R10] mono duplicate bit 9 copies capture to both slots
// [R11] bit 8 inverts bit clock, bit 7 sync
// [R12] width field 6:5 picks 16/20/24/32, reset 24
// [R13] format field 4:3 picks rj/lj/i2s/dsp, reset i2s
// [R14] right justified caps width at 24 bits
// [R15] divider code picks 1..32, codes 110/111 reserved
// [R16] swap bits place playback and capture slot
// [R17] master bit resets low, clocks are inputs
// [R18] data changes after falling edge, sampled rising
`default_nettype none
module mcap_device
	import mcap_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	mcap_link.device         link,
	input  wire logic        ctrl_wr_en,
	input  wire logic [2:0]  ctrl_index,
	input  wire logic [9:0]  ctrl_wdata,
	output logic      [9:0]  ctrl_rdata,
	input  wire logic [31:0] capture_sample,
	input  wire logic        capture_valid,
	output logic             capture_ready,
	output logic      [31:0] playback_sample,
	output logic             playback_valid
);

	// ==========================================================
	// control words
	logic [9:0] fmt_r;
	logic [9:0] fmt_nxt;
	logic [9:0] clkc_r;
	logic [9:0] clkc_nxt;
	logic [9:0] rdata_nxt;

	// write takes effect next cycle; undefined bits are dropped and read as zero
	always_comb begin
		fmt_nxt   = fmt_r;
		clkc_nxt  = clkc_r;
		rdata_nxt = '0;
		if (ctrl_wr_en && ctrl_index == FMT_CTRL_INDEX)
			fmt_nxt = ctrl_wdata & FMT_CTRL_MASK;
		if (ctrl_wr_en && ctrl_index == CLK_CTRL_INDEX)
			clkc_nxt = ctrl_wdata & CLK_CTRL_MASK;
		if (ctrl_index == FMT_CTRL_INDEX)
			rdata_nxt = fmt_r;
		else if (ctrl_index == CLK_CTRL_INDEX)
			rdata_nxt = clkc_r;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fmt_r      <= FMT_CTRL_RESET;  // [R12]
			clkc_r     <= CLK_CTRL_RESET;  // [R17]
			ctrl_rdata <= '0;
		end else begin
			fmt_r      <= fmt_nxt;
			clkc_r     <= clkc_nxt;
			ctrl_rdata <= rdata_nxt;
		end
	end

	// ==========================================================
	// field decode
	mcap_fmt_t  fmt;
	logic [1:0] wl;
	logic       syncpol;
	logic       bcinv;
	logic       monodup;
	logic       pswap;
	logic       cswap;
	logic       master;
	logic       dsp;
	logic [2:0] dcode;
	logic [6:0] half;

	assign fmt     = mcap_fmt_t'(fmt_r[FORMAT_LSB +: 2]);  // [R13]
	assign wl      = fmt_r[WIDTH_LSB +: 2];                // [R12]
	assign syncpol = fmt_r[SYNC_POL_BIT];
	assign bcinv   = fmt_r[BCLK_INV_BIT];
	assign monodup = fmt_r[MONO_DUP_BIT];
	assign pswap   = fmt_r[PB_SWAP_BIT];
	assign cswap   = fmt_r[CAP_SWAP_BIT];
	assign master  = clkc_r[MASTER_BIT];
	assign dsp     = fmt == MCAP_FMT_DSP;
	// reserved divider codes hold the slowest rate rather than stopping the clock
	assign dcode   = (clkc_r[DIVIDER_LSB +: 3] > DIV_CODE_MAX) ? DIV_CODE_MAX : clkc_r[DIVIDER_LSB +: 3];  // [R15]
	assign half    = 7'(BCLK_HALF_BASE << dcode);

	// ==========================================================
	// clock generator, master mode only
	logic [6:0] div_r;
	logic [6:0] div_nxt;
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic       gb_r;
	logic       gb_nxt;
	logic       gf_r;
	logic       gf_nxt;
	logic       pin_r;
	logic       pin_nxt;

	// bit clock toggles every half period; frame counts 32 falls per phase.
	// the >= compare keeps a divider change mid-run from wrapping the count
	always_comb begin
		div_nxt = div_r + 7'h01;
		gb_nxt  = gb_r;
		cnt_nxt = cnt_r;
		if (!master) begin
			div_nxt = '0;
			gb_nxt  = 1'b0;
			cnt_nxt = '0;
		end else if (div_r >= half - 7'h01) begin  // [R9]
			div_nxt = '0;
			gb_nxt  = ~gb_r;
			if (gb_r)
				cnt_nxt = cnt_r + 6'h01;
		end
		// sync changes together with the bit clock fall
		if (dsp)
			gf_nxt = cnt_nxt == 6'h00;
		else
			gf_nxt = ((fmt == MCAP_FMT_I2S) ? cnt_nxt[5] : ~cnt_nxt[5]) ^ syncpol;  // [R11]
		pin_nxt = gb_nxt ^ bcinv;  // [R11]
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= '0;
			cnt_r <= '0;
			gb_r  <= 1'b0;
			gf_r  <= 1'b0;
			pin_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			cnt_r <= cnt_nxt;
			gb_r  <= gb_nxt;
			gf_r  <= gf_nxt;
			pin_r <= pin_nxt;
		end
	end

	// ==========================================================
	// link decode and shifters
	logic        lb;
	logic        fr;
	logic        fall;
	logic        rise;
	logic        rnow;
	logic        trans;
	logic        load;
	logic        bprev_r;
	logic        bprev_nxt;
	logic        fprev_r;
	logic        fprev_nxt;
	logic        ph_r;
	logic        ph_nxt;
	logic [6:0]  k_r;
	logic [6:0]  k_nxt;
	logic        out_r;
	logic        out_nxt;
	logic [31:0] cw_r;
	logic [31:0] cw_nxt;
	logic [31:0] sh_r;
	logic [31:0] sh_nxt;
	logic [31:0] ps_nxt;
	logic        pv_nxt;
	mcap_slot_t  sn;
	mcap_slot_t  sc;

	// in master mode the link view is the generator's own state, in slave the pins
	always_comb begin
		lb    = master ? gb_r : (link.bclk ^ bcinv);  // [R2] [R3] [R11]
		fr    = master ? gf_r : link.frame;
		fall  = bprev_r & ~lb;
		rise  = ~bprev_r & lb;
		rnow  = ((fmt == MCAP_FMT_I2S) ? fr : ~fr) ^ syncpol;  // [R11]
		// dsp frames start on the sync rising edge only
		trans = dsp ? (fr & ~fprev_r) : (rnow != ph_r);
		load  = fall & trans & (dsp | ~rnow);
		bprev_nxt = lb;
		fprev_nxt = fall ? fr : fprev_r;
		ph_nxt    = fall ? (rnow & ~dsp) : ph_r;
		k_nxt     = fall ? (trans ? 7'h00 : ((k_r == K_IDLE) ? K_IDLE : k_r + 7'h01)) : k_r;
		sn = mcap_slot(fmt, wl, syncpol, k_nxt, ph_nxt);  // [R4]
		sc = mcap_slot(fmt, wl, syncpol, k_r, ph_r);
		// one capture word per frame; zero goes out when none is offered
		capture_ready = load;
		cw_nxt = load ? (capture_valid ? capture_sample : '0) : cw_r;
		out_nxt = out_r;
		// right slot bits read the held word, its last bit can share the loading fall
		if (fall)  // [R18]
			out_nxt = sn.hit & (monodup | (sn.right == cswap))
				& (sn.right ? cw_r[sn.idx] : cw_nxt[sn.idx]);  // [R10] [R16]
		// playback is sampled on the rise, only in its selected slot
		sh_nxt = sh_r;
		ps_nxt = playback_sample;
		pv_nxt = 1'b0;
		if (rise && sc.hit && sc.right == pswap) begin  // [R16] [R18]
			sh_nxt = {sh_r[30:0], link.playback_data_in};
			if (sc.idx == 5'h00) begin
				ps_nxt = sh_nxt;
				pv_nxt = 1'b1;
				sh_nxt = '0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bprev_r         <= 1'b0;
			fprev_r         <= 1'b0;
			ph_r            <= 1'b0;
			k_r             <= K_IDLE;
			out_r           <= 1'b0;
			cw_r            <= '0;
			sh_r            <= '0;
			playback_sample <= '0;
			playback_valid  <= 1'b0;
		end else begin
			bprev_r         <= bprev_nxt;
			fprev_r         <= fprev_nxt;
			ph_r            <= ph_nxt;
			k_r             <= k_nxt;
			out_r           <= out_nxt;
			cw_r            <= cw_nxt;
			sh_r            <= sh_nxt;
			playback_sample <= ps_nxt;
			playback_valid  <= pv_nxt;
		end
	end

	// ==========================================================
	// pins
	assign link.bclk_dev_o       = pin_r;
	assign link.bclk_dev_oe      = master;  // [R2] [R17]
	assign link.frame_dev_o      = gf_r;
	assign link.frame_dev_oe     = master;
	assign link.capture_data_out = out_r;   // [R1]

endmodule // mcap_device
`default_nettype wire

// [mcap_pkg.sv]
// constants, types and slot decoder shared by both ends of the mono codec audio port
`default_nettype none
package mcap_pkg;

	// ==========================================================
	// control words (index form, byte address = 4 x index)
	localparam logic [2:0] FMT_CTRL_INDEX = 3'h4;
	localparam logic [2:0] CLK_CTRL_INDEX = 3'h6;
	localparam logic [9:0] FMT_CTRL_RESET = 10'h050;  // 24 bit, i2s, normal polarity
	localparam logic [9:0] FMT_CTRL_MASK  = 10'h3FE;
	localparam logic [9:0] CLK_CTRL_RESET = 10'h000;  // slave, divide by 1
	localparam logic [9:0] CLK_CTRL_MASK  = 10'h01D;

	// ==========================================================
	// field positions
	localparam int MONO_DUP_BIT  = 9;
	localparam int BCLK_INV_BIT  = 8;
	localparam int SYNC_POL_BIT  = 7;
	localparam int WIDTH_LSB     = 5;
	localparam int FORMAT_LSB    = 3;
	localparam int PB_SWAP_BIT   = 2;
	localparam int CAP_SWAP_BIT  = 1;
	localparam int DIVIDER_LSB   = 2;
	localparam int MASTER_BIT    = 0;

	// ==========================================================
	// timing of the generated clocks, in system clock cycles
	localparam logic [6:0] BCLK_HALF_BASE = 7'h02;  // internal master clock = clock / 4
	localparam logic [2:0] DIV_CODE_MAX   = 3'h5;   // reserved codes fall back to /32
	localparam logic [5:0] PHASE_BCLKS    = 6'h20;  // bit clocks per word sync phase
	localparam logic [6:0] K_IDLE         = 7'h7F;  // bit counter parked, no slot hit

	typedef enum logic [1:0] {MCAP_FMT_RJ, MCAP_FMT_LJ, MCAP_FMT_I2S, MCAP_FMT_DSP} mcap_fmt_t;

	typedef struct packed {
		logic       hit;
		logic       right;
		logic [4:0] idx;
	} mcap_slot_t;

	// maps rising edge number k after a sync transition onto a sample bit
	function automatic mcap_slot_t mcap_slot(input mcap_fmt_t fmt, input logic [1:0] wl,
			input logic modeb, input logic [6:0] k, input logic right);
		logic [6:0] w;
		logic [6:0] j;
		mcap_slot_t s;
		case (wl)
			2'h0: w = 7'h10;
			2'h1: w = 7'h14;
			2'h2: w = 7'h18;
			default: w = (fmt == MCAP_FMT_RJ) ? 7'h18 : 7'h20;  // [R14]
		endcase
		s = '0;
		s.right = right;
		j = k - {6'h00, ~modeb};
		case (fmt)
			MCAP_FMT_LJ: begin
				s.hit = k < w;  // [R5]
				s.idx = 5'(w - 7'h01 - k);
			end
			// a 32 bit word fills its phase, so its lsb lands on rise 0 of the next phase
			MCAP_FMT_I2S: begin
				s.hit = ((k != 7'h00) || (w == 7'h20)) && (k <= w);  // [R7]
				s.right = (k == 7'h00) ? ~right : right;
				s.idx = 5'(w - k);
			end
			MCAP_FMT_RJ: begin
				s.hit = (k >= 7'(PHASE_BCLKS) - w) && (k < 7'(PHASE_BCLKS));  // [R6]
				s.idx = 5'(7'h1F - k);
			end
			// mode a with 32 bit words: the right lsb rides on the next frame's sync bit clock
			default: begin
				s.hit = (j < (w << 1)) || (!modeb && (k == 7'h00) && (w == 7'h20));  // [R8]
				s.right = j >= w;
				s.idx = s.right ? 5'((w << 1) - 7'h01 - j) : 5'(w - 7'h01 - j);
			end
		endcase
		return s;  // [R4]
	endfunction

endpackage
`default_nettype wire

// [mcap_link.sv]
// link wires between the codec audio port and its host
`default_nettype none
interface mcap_link;
	logic bclk_dev_o;
	logic bclk_dev_oe;
	logic frame_dev_o;
	logic frame_dev_oe;
	logic bclk_host_o;
	logic bclk_host_oe;
	logic frame_host_o;
	logic frame_host_oe;
	logic capture_data_out;
	logic playback_data_in;
	logic bclk;
	logic frame;

	// resolved pin levels; an undriven clock line reads low
	assign bclk  = bclk_dev_oe ? bclk_dev_o : (bclk_host_oe & bclk_host_o);
	assign frame = frame_dev_oe ? frame_dev_o : (frame_host_oe & frame_host_o);

	modport device (output bclk_dev_o, bclk_dev_oe, frame_dev_o, frame_dev_oe, capture_data_out,
		input bclk, frame, playback_data_in);
	modport host (output bclk_host_o, bclk_host_oe, frame_host_o, frame_host_oe, playback_data_in,
		input bclk, frame, capture_data_out);
endinterface
`default_nettype wire

// [mcap_host.sv]
// host end: drives playback data, receives capture data, makes the clocks when master
`default_nettype none
module mcap_host
	import mcap_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	mcap_link.host           link,
	input  wire logic [9:0]  cfg,
	input  wire logic        host_master,
	input  wire logic [2:0]  host_div,
	input  wire logic [31:0] tx_left,
	input  wire logic [31:0] tx_right,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	output logic      [31:0] rx_sample,
	output logic             rx_right,
	output logic             rx_valid
);

	// ==========================================================
	// configuration
	mcap_fmt_t  fmt;
	logic [1:0] wl;
	logic       syncpol, bcinv, dsp;
	logic [2:0] dcode;
	logic [6:0] half;
	assign fmt     = mcap_fmt_t'(cfg[FORMAT_LSB +: 2]);
	assign wl      = cfg[WIDTH_LSB +: 2];
	assign syncpol = cfg[SYNC_POL_BIT];
	assign bcinv   = cfg[BCLK_INV_BIT];
	assign dsp     = fmt == MCAP_FMT_DSP;
	assign dcode   = (host_div > DIV_CODE_MAX) ? DIV_CODE_MAX : host_div;
	assign half    = 7'(BCLK_HALF_BASE << dcode);

	logic [6:0]  div_r, div_nxt, k_r, k_nxt;
	logic [5:0]  cnt_r, cnt_nxt;
	logic        gb_r, gb_nxt, gf_r, gf_nxt, pin_r, pin_nxt;
	logic        bprev_r, bprev_nxt, fprev_r, fprev_nxt, ph_r, ph_nxt, out_r, out_nxt;
	logic        lb, fr, fall, rise, rnow, trans, load, rv_nxt, rr_nxt;
	logic [31:0] wl_r, wl_nxt, wr_r, wr_nxt, sh_r, sh_nxt, rs_nxt;
	mcap_slot_t  sn, sc;

	// ==========================================================
	// clock generation and link decode, mirror of the device end
	always_comb begin
		div_nxt = div_r + 7'h01;
		gb_nxt  = gb_r;
		cnt_nxt = cnt_r;
		if (!host_master) begin
			div_nxt = '0;
			gb_nxt  = 1'b0;
			cnt_nxt = '0;
		end else if (div_r >= half - 7'h01) begin
			div_nxt = '0;
			gb_nxt  = ~gb_r;
			if (gb_r)
				cnt_nxt = cnt_r + 6'h01;
		end
		gf_nxt  = dsp ? (cnt_nxt == 6'h00) : (((fmt == MCAP_FMT_I2S) ? cnt_nxt[5] : ~cnt_nxt[5]) ^ syncpol);
		pin_nxt = gb_nxt ^ bcinv;
		lb      = host_master ? gb_r : (link.bclk ^ bcinv);
		fr      = host_master ? gf_r : link.frame;
		fall    = bprev_r & ~lb;
		rise    = ~bprev_r & lb;
		rnow    = ((fmt == MCAP_FMT_I2S) ? fr : ~fr) ^ syncpol;
		trans   = dsp ? (fr & ~fprev_r) : (rnow != ph_r);
		load    = fall & trans & (dsp | ~rnow);
		bprev_nxt = lb;
		fprev_nxt = fall ? fr : fprev_r;
		ph_nxt    = fall ? (rnow & ~dsp) : ph_r;
		k_nxt     = fall ? (trans ? 7'h00 : ((k_r == K_IDLE) ? K_IDLE : k_r + 7'h01)) : k_r;
		sn = mcap_slot(fmt, wl, syncpol, k_nxt, ph_nxt);
		sc = mcap_slot(fmt, wl, syncpol, k_r, ph_r);
		// playback words are taken at the start of each frame, zero on underrun
		tx_ready = load;
		wl_nxt   = load ? (tx_valid ? tx_left : '0) : wl_r;
		wr_nxt   = load ? (tx_valid ? tx_right : '0) : wr_r;
		out_nxt  = out_r;
		if (fall)
			out_nxt = sn.hit & (sn.right ? wr_r[sn.idx] : wl_nxt[sn.idx]);  // [R18]
		// capture words are shifted in on the rising edge, both slots
		sh_nxt = sh_r;
		rs_nxt = rx_sample;
		rr_nxt = rx_right;
		rv_nxt = 1'b0;
		if (rise && sc.hit) begin
			sh_nxt = {sh_r[30:0], link.capture_data_out};
			if (sc.idx == 5'h00) begin
				rs_nxt = sh_nxt;
				rr_nxt = sc.right;
				rv_nxt = 1'b1;
				sh_nxt = '0;
			end
		end
	end

	// registers; host only drives the clocks when it is master  [R3]
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= '0; cnt_r <= '0; gb_r <= 1'b0; gf_r <= 1'b0; pin_r <= 1'b0;
			bprev_r <= 1'b0; fprev_r <= 1'b0; ph_r <= 1'b0; k_r <= K_IDLE; out_r <= 1'b0;
			wl_r <= '0; wr_r <= '0; sh_r <= '0; rx_sample <= '0; rx_right <= 1'b0; rx_valid <= 1'b0;
		end else begin
			div_r <= div_nxt; cnt_r <= cnt_nxt; gb_r <= gb_nxt; gf_r <= gf_nxt; pin_r <= pin_nxt;
			bprev_r <= bprev_nxt; fprev_r <= fprev_nxt; ph_r <= ph_nxt; k_r <= k_nxt; out_r <= out_nxt;
			wl_r <= wl_nxt; wr_r <= wr_nxt; sh_r <= sh_nxt; rx_sample <= rs_nxt; rx_right <= rr_nxt;
			rx_valid <= rv_nxt;
		end
	end

	assign link.bclk_host_o      = pin_r;
	assign link.bclk_host_oe     = host_master;
	assign link.frame_host_o     = gf_r;
	assign link.frame_host_oe    = host_master;
	assign link.playback_data_in = out_r;

endmodule // mcap_host
`default_nettype wire

// [mcap_link_sva.sv]
// assertions on the link wires between the codec audio port and its host
`default_nettype none
module mcap_link_sva (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic bclk_dev_oe,
	input wire logic frame_dev_oe,
	input wire logic bclk_host_oe,
	input wire logic frame_host_oe,
	input wire logic bclk,
	input wire logic capture_data_out,
	input wire logic playback_data_in
);
	// ==========================================================
	// one clock domain, everything quiet while in reset
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// clock ownership: both clocks change hands together, never two drivers
	property p_dev_oe_pair;
		bclk_dev_oe == frame_dev_oe;
	endproperty
	a_dev_oe_pair: assert property (p_dev_oe_pair)
		else $error("device clock enables differ");

	property p_host_oe_pair;
		bclk_host_oe == frame_host_oe;
	endproperty
	a_host_oe_pair: assert property (p_host_oe_pair)
		else $error("host clock enables differ");

	property p_one_master;
		!(bclk_dev_oe && bclk_host_oe);
	endproperty
	a_one_master: assert property (p_one_master)
		else $error("both ends drive the bit clock");

	// after reset the device listens, so its clock pins must be released when reset ends
	property p_reset_slave;
		$rose(rst_n) |-> !bclk_dev_oe && !frame_dev_oe;
	endproperty
	a_reset_slave: assert property (p_reset_slave)
		else $error("device drives clocks after reset");

	// ==========================================================
	// generated bit clock: half period at least two cycles, at most /32 long
	property p_bclk_min_half;
		bclk_dev_oe && $past(bclk_dev_oe) && $changed(bclk) |=> $stable(bclk) || !bclk_dev_oe;
	endproperty
	a_bclk_min_half: assert property (p_bclk_min_half)
		else $error("bit clock half period too short");

	property p_bclk_runs;
		bclk_dev_oe |-> ##[0:130] ($changed(bclk) || !bclk_dev_oe);
	endproperty
	a_bclk_runs: assert property (p_bclk_runs)
		else $error("generated bit clock stalled");

	// ==========================================================
	// data lines only move just after a bit clock edge, never on their own
	property p_cap_edge;
		(bclk_dev_oe || bclk_host_oe) && $changed(capture_data_out)
			|-> $changed(bclk) || ($past(bclk) != $past(bclk, 2)) || ($past(bclk, 2) != $past(bclk, 3));
	endproperty
	a_cap_edge: assert property (p_cap_edge)
		else $error("capture data moved away from a clock edge");

	property p_pb_edge;
		(bclk_dev_oe || bclk_host_oe) && $changed(playback_data_in)
			|-> $changed(bclk) || ($past(bclk) != $past(bclk, 2)) || ($past(bclk, 2) != $past(bclk, 3));
	endproperty
	a_pb_edge: assert property (p_pb_edge)
		else $error("playback data moved away from a clock edge");
endmodule // mcap_link_sva
`default_nettype wire

// [tb.sv]
// self-checking bench: codec audio port and host joined across the link
`default_nettype none
module tb
	import mcap_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clock;
	logic        rst_n;
	logic        ctrl_wr_en;
	logic [2:0]  ctrl_index;
	logic [9:0]  ctrl_wdata;
	logic [9:0]  ctrl_rdata;
	logic [31:0] capture_sample;
	logic        capture_valid;
	logic        capture_ready;
	logic [31:0] playback_sample;
	logic        playback_valid;
	logic [9:0]  cfg;
	logic        host_master;
	logic [2:0]  host_div;
	logic [31:0] tx_left;
	logic [31:0] tx_right;
	logic        tx_valid;
	logic        tx_ready;
	logic [31:0] rx_sample;
	logic        rx_right;
	logic        rx_valid;
	int          failures;
	int          num_checks;
	int          cycles = 0;
	integer      seed;

	// ==========================================================
	// both ends face each other across one link, checker watches the wires
	mcap_link link ();
	mcap_device i_mcap_device (.clock(clock), .rst_n(rst_n), .link(link), .ctrl_wr_en(ctrl_wr_en),
		.ctrl_index(ctrl_index), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
		.capture_sample(capture_sample), .capture_valid(capture_valid), .capture_ready(capture_ready),
		.playback_sample(playback_sample), .playback_valid(playback_valid));
	mcap_host i_mcap_host (.clock(clock), .rst_n(rst_n), .link(link), .cfg(cfg), .host_master(host_master),
		.host_div(host_div), .tx_left(tx_left), .tx_right(tx_right), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_sample(rx_sample), .rx_right(rx_right), .rx_valid(rx_valid));
	mcap_link_sva i_mcap_link_sva (.clock(clock), .rst_n(rst_n), .bclk_dev_oe(link.bclk_dev_oe),
		.frame_dev_oe(link.frame_dev_oe), .bclk_host_oe(link.bclk_host_oe),
		.frame_host_oe(link.frame_host_oe), .bclk(link.bclk), .capture_data_out(link.capture_data_out),
		.playback_data_in(link.playback_data_in));

	// ==========================================================
	// clock and hang guard; the ceiling leaves room over the ~25k cycles needed
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			failures = failures + 1;
			wrap_up();
		end
	end

	// ==========================================================
	// shared tasks and expectation helpers
	task automatic wrap_up();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [2:0] idx, input logic [9:0] data);
		@(posedge clock);
		ctrl_wr_en <= 1'b1;
		ctrl_index <= idx;
		ctrl_wdata <= data;
		@(posedge clock);
		ctrl_wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] idx, output logic [9:0] data);
		@(posedge clock);
		ctrl_index <= idx;
		repeat (3) @(posedge clock);
		#1 data = ctrl_rdata;
	endtask

	// counts cycles up to the next rising bit clock, sampled where settled
	task automatic bclk_rise(output int n);
		logic last;
		n = 0;
		do begin
			last = link.bclk;
			@(posedge clock);
			#1 n++;
		end while (!(last === 1'b0 && link.bclk === 1'b1) && n < 400);
	endtask

	// which 0: host receive of the given slot, which 1: device playback word
	task automatic wait_pulse(input int which, input logic slot, output logic [31:0] data);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			#1 n++;
		end while (!(which ? playback_valid === 1'b1 : (rx_valid === 1'b1 && rx_right === slot)) && n < 1000);
		data = (n >= 1000) ? 32'hxxxx_xxxx : (which ? playback_sample : rx_sample);
	endtask

	function automatic logic [31:0] width_mask(input logic [1:0] fmt, input logic [1:0] wl);
		case (wl)
			2'h0: return 32'h0000_FFFF;
			2'h1: return 32'h000F_FFFF;
			2'h2: return 32'h00FF_FFFF;
			default: return (fmt == 2'h0) ? 32'h00FF_FFFF : 32'hFFFF_FFFF;
		endcase
	endfunction

	// ==========================================================
	// main sequence: control words, divider, then data over every format
	initial begin
		logic [9:0]  v;
		logic [9:0]  fw;
		logic [31:0] got;
		logic [31:0] m;
		logic        dm;
		int          t;
		seed = 32'hd133;
		rst_n = 1'b0;
		ctrl_wr_en = 1'b0;
		ctrl_index = 3'h0;
		ctrl_wdata = 10'h000;
		capture_sample = 32'h0000_0000;
		capture_valid = 1'b1;
		cfg = 10'h050;
		host_master = 1'b0;
		host_div = 3'h0;
		tx_left = 32'h0000_0000;
		tx_right = 32'h0000_0000;
		tx_valid = 1'b1;
		failures = 0;
		num_checks = 0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		// reset values, dropped bits, and a write to an unused index
		rd(FMT_CTRL_INDEX, v);
		check(32'(v), 32'h0000_0050);
		rd(CLK_CTRL_INDEX, v);
		check(32'(v), 32'h0000_0000);
		wr(FMT_CTRL_INDEX, 10'h3FF);
		rd(FMT_CTRL_INDEX, v);
		check(32'(v), 32'h0000_03FE);
		wr(CLK_CTRL_INDEX, 10'h3FE);
		wr(3'h5, 10'h2AA);
		rd(CLK_CTRL_INDEX, v);
		check(32'(v), 32'h0000_001C);
		rd(FMT_CTRL_INDEX, v);
		check(32'(v), 32'h0000_03FE);
		$display("control word test done");
		// every divider code in master mode, reserved codes included
		wr(FMT_CTRL_INDEX, 10'h050);
		for (int c = 0; c < 8; c++) begin
			wr(CLK_CTRL_INDEX, {5'h00, 3'(c), 2'h1});
			bclk_rise(t);
			bclk_rise(t);
			bclk_rise(t);
			check(32'(t), 32'(4 << ((c > 5) ? 5 : c)));
		end
		$display("divider test done");
		// all formats and widths, random bit clock polarity, sync polarity from the loop index, swaps, duplicate and master side
		for (int i = 0; i < 16; i++) begin
			fw = 10'($random(seed)) & 10'h386;
			fw[7] = i[0] ^ i[1];
			fw[6:5] = 2'(i);
			fw[4:3] = 2'(i >> 2);
			dm = 1'($random(seed));
			host_master <= 1'b0;
			wr(CLK_CTRL_INDEX, 10'h000);
			wr(FMT_CTRL_INDEX, fw);
			cfg <= fw;
			capture_sample <= (i == 0) ? 32'hFFFF_FFFF : 32'($random(seed));
			tx_left <= (i == 15) ? 32'hAAAA_5555 : 32'($random(seed));
			tx_right <= 32'($random(seed));
			repeat (4) @(posedge clock);
			host_master <= !dm;
			wr(CLK_CTRL_INDEX, {9'h000, dm});
			repeat (800) @(posedge clock);
			m = width_mask(fw[4:3], fw[6:5]);
			wait_pulse(0, fw[1], got);
			case (fw[4:3])
				2'h0: check(got, capture_sample & m);
				2'h1: check(got, capture_sample & m);
				2'h2: check(got, capture_sample & m);
				default: check(got, capture_sample & m);
			endcase
			// the other slot carries the mono word only when duplicated, zeros otherwise
			wait_pulse(0, !fw[1], got);
			check(got, fw[9] ? (capture_sample & m) : 32'h0000_0000);
			wait_pulse(1, 1'b0, got);
			check(got, (fw[2] ? tx_right : tx_left) & m);
		end
		$display("data transfer test done");
		wrap_up();
	end
endmodule // tb
`default_nettype wire
